/* hdl/acl_defs.svh */
// constants of the access rule entry matcher: offsets, fields, resets, codes
// assumes a 32-bit APB slave with byte addresses and one word per register
`ifndef ACL_DEFS_SVH
`define ACL_DEFS_SVH

`define OFS_CTRL      8'h00
`define OFS_SRC_LO    8'h04
`define OFS_SRC_HI    8'h08
`define OFS_DST_LO    8'h0C
`define OFS_DST_HI    8'h10
`define OFS_VID_PROTO 8'h14
`define OFS_SIP       8'h18
`define OFS_SIP_MASK  8'h1C
`define OFS_DIP       8'h20
`define OFS_DIP_MASK  8'h24
`define OFS_COUNT     8'h28
`define OFS_STATUS    8'h2C

`define CTRL_FTYPE    1:0
`define CTRL_DENY     2
`define CTRL_SRC_EN   3
`define CTRL_DST_SEL  6:4
`define CTRL_VID      7
`define CTRL_PRIO_EN  8
`define CTRL_PRIO     11:9
`define CTRL_PROTO    14:12
`define CTRL_TTL      16:15
`define CTRL_FRAG     18:17
`define CTRL_OPT      20:19
`define CTRL_SIP      22:21
`define CTRL_DIP      24:23
`define VP_VID        11:0
`define VP_PROTO      23:16

`define VID_RESET     12'h001
`define VID_NONE      12'h000
`define ETYPE_MIN     16'h0600
`define PROTO_ICMP    8'h01
`define PROTO_TCP     8'h06
`define PROTO_UDP     8'h11
`define RESULT_DELAY  1

`endif

/* hdl/acl_pkg.sv */
// types of the access rule entry matcher
// assumes acl_defs.svh supplies the numeric constants
package acl_pkg;
  typedef enum logic [1:0] {FT_ANY, FT_ETYPE, FT_ARP, FT_IPV4} frame_type_t;
  typedef enum logic [2:0] {
    MAC_ANY, MAC_GROUP, MAC_ALL_HOSTS, MAC_SINGLE, MAC_SPECIFIC
  } mac_sel_t;
  typedef enum logic [2:0] {PR_ANY, PR_SPECIFIC, PR_ICMP, PR_UDP, PR_TCP} proto_sel_t;
  typedef enum logic [1:0] {TRI_ANY, TRI_NO, TRI_YES} tri_sel_t;
  typedef enum logic [1:0] {IP_ANY, IP_HOST, IP_NET} ip_sel_t;
endpackage

/* hdl/frame_acl_entry_matcher.sv */
// one access rule entry: APB configuration, frame criteria match, counter
// assumes decoded header fields arrive synchronous to clk with hdr_valid
`timescale 1ns/1ps
`include "acl_defs.svh"
module frame_acl_entry_matcher import acl_pkg::*; #(
  parameter int CNT_W  = 32,
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              hdr_valid,
  input  wire logic              frm_is_arp,
  input  wire logic              frm_is_ipv4,
  input  wire logic [15:0]       frm_len_type,
  input  wire logic [47:0]       frm_source_hw_address,
  input  wire logic [47:0]       frm_destination_hw_address,
  input  wire logic [11:0]       frm_vid,
  input  wire logic [2:0]        frm_prio,
  input  wire logic [7:0]        frm_ip_proto,
  input  wire logic [7:0]        frm_ttl,
  input  wire logic              frm_more_fragments_bit,
  input  wire logic [12:0]       frm_fragment_position,
  input  wire logic              frm_ip_options,
  input  wire logic [31:0]       frm_source_net_address,
  input  wire logic [31:0]       frm_destination_net_address,
  output logic                   match_valid,
  output logic                   match_hit,
  output logic                   match_drop
);

  typedef struct packed {
    frame_type_t      ftype;
    logic             deny;
    logic             src_spec;
    mac_sel_t         dst_sel;
    logic             vid_spec;
    logic             prio_spec;
    logic [2:0]       prio;
    proto_sel_t       proto_sel;
    tri_sel_t         ttl_sel;
    tri_sel_t         frag_sel;
    tri_sel_t         opt_sel;
    ip_sel_t          sip_sel;
    ip_sel_t          dip_sel;
    logic [47:0]      src_hw;
    logic [47:0]      dst_hw;
    logic [11:0]      vid;
    logic [7:0]       proto;
    logic [31:0]      source_net_address;
    logic [31:0]      sip_mask;
    logic [31:0]      destination_net_address;
    logic [31:0]      dip_mask;
    logic [CNT_W-1:0] count;
    logic             res_valid;
    logic             res_hit;
    logic             res_drop;
    logic [31:0]      rdata;
    logic             rerr;
  } state_t;

  state_t s_reg;
  state_t s_next;

  function automatic logic tri_ok(input tri_sel_t sel, input logic flag);
    unique case (sel)
      TRI_ANY: tri_ok = 1'b1;
      TRI_NO:  tri_ok = !flag;
      TRI_YES: tri_ok = flag;
      default: tri_ok = 1'b0;
    endcase
  endfunction

  function automatic logic ip_ok(input ip_sel_t sel, input logic [31:0] addr,
                                 input logic [31:0] val, input logic [31:0] mask);
    unique case (sel)
      IP_ANY:  ip_ok = 1'b1;
      IP_HOST: ip_ok = (addr == val);
      IP_NET:  ip_ok = ((addr & mask) == (val & mask));
      default: ip_ok = 1'b0;
    endcase
  endfunction

  function automatic logic decode_hit(input logic [ADDR_W-1:0] a);
    decode_hit = (a[1:0] == 2'b00) && (a <= ADDR_W'(`OFS_STATUS));
  endfunction

  logic setup;
  logic wr_access;
  logic frm_bcast;
  logic frm_group;
  logic frm_etype;
  logic type_ok;
  logic src_ok;
  logic dst_ok;
  logic vid_ok;
  logic prio_ok;
  logic proto_ok;
  logic ip_crit_ok;
  logic hit_c;
  logic cnt_clear;

  assign setup     = psel && !penable;
  assign wr_access = psel && penable && pwrite && decode_hit(paddr);
  assign cnt_clear = wr_access && (paddr == ADDR_W'(`OFS_COUNT));
  // zero wait states: read data was captured in the setup cycle
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && s_reg.rerr;
  assign prdata    = s_reg.rdata;

  assign match_valid = s_reg.res_valid;
  assign match_hit   = s_reg.res_hit;
  assign match_drop  = s_reg.res_drop;

  always_comb begin
    frm_bcast = &frm_destination_hw_address;
    frm_group = frm_destination_hw_address[40] && !frm_bcast;
    frm_etype = !frm_is_arp && !frm_is_ipv4 && (frm_len_type >= `ETYPE_MIN);

    unique case (s_reg.ftype)
      FT_ANY:   type_ok = 1'b1;
      FT_ETYPE: type_ok = frm_etype;
      FT_ARP:   type_ok = frm_is_arp;
      FT_IPV4:  type_ok = frm_is_ipv4;
    endcase

    // source filter only exists for Ethernet-type and ARP entries
    src_ok = !((s_reg.ftype == FT_ETYPE) || (s_reg.ftype == FT_ARP))
             || !s_reg.src_spec
             || (frm_source_hw_address == s_reg.src_hw);

    unique case (s_reg.dst_sel)
      MAC_ANY:       dst_ok = 1'b1;
      MAC_GROUP:     dst_ok = frm_group;
      MAC_ALL_HOSTS: dst_ok = frm_bcast;
      MAC_SINGLE:    dst_ok = !frm_destination_hw_address[40];
      MAC_SPECIFIC:  dst_ok = (frm_destination_hw_address == s_reg.dst_hw);
      default:       dst_ok = 1'b0;
    endcase

    vid_ok  = !s_reg.vid_spec || (frm_vid == s_reg.vid);
    prio_ok = !s_reg.prio_spec || (frm_prio == s_reg.prio);

    unique case (s_reg.proto_sel)
      PR_ANY:      proto_ok = 1'b1;
      PR_SPECIFIC: proto_ok = (frm_ip_proto == s_reg.proto);
      PR_ICMP:     proto_ok = (frm_ip_proto == `PROTO_ICMP);
      PR_UDP:      proto_ok = (frm_ip_proto == `PROTO_UDP);
      PR_TCP:      proto_ok = (frm_ip_proto == `PROTO_TCP);
      default:     proto_ok = 1'b0;
    endcase

    ip_crit_ok = proto_ok
      && tri_ok(s_reg.ttl_sel, frm_ttl != 8'h00)
      && tri_ok(s_reg.frag_sel,
                frm_more_fragments_bit || (frm_fragment_position != 13'h0000))
      && tri_ok(s_reg.opt_sel, frm_ip_options)
      && ip_ok(s_reg.sip_sel, frm_source_net_address,
               s_reg.source_net_address, s_reg.sip_mask)
      && ip_ok(s_reg.dip_sel, frm_destination_net_address,
               s_reg.destination_net_address, s_reg.dip_mask);

    // every criterion ANDed; an unused one is constant true
    hit_c = type_ok && src_ok && dst_ok && vid_ok && prio_ok
            && ((s_reg.ftype != FT_IPV4) || ip_crit_ok);

    s_next = s_reg;

    // one-cycle result after the strobe
    s_next.res_valid = hdr_valid;
    s_next.res_hit   = hdr_valid && hit_c;
    s_next.res_drop  = hdr_valid && hit_c && s_reg.deny;

    if (wr_access) begin
      unique case (paddr)
        ADDR_W'(`OFS_CTRL): begin
          s_next.ftype     = frame_type_t'(pwdata[`CTRL_FTYPE]);
          s_next.deny      = pwdata[`CTRL_DENY];
          s_next.src_spec  = pwdata[`CTRL_SRC_EN];
          s_next.dst_sel   = mac_sel_t'(pwdata[`CTRL_DST_SEL]);
          s_next.vid_spec  = pwdata[`CTRL_VID];
          s_next.prio_spec = pwdata[`CTRL_PRIO_EN];
          s_next.prio      = pwdata[`CTRL_PRIO];
          s_next.proto_sel = proto_sel_t'(pwdata[`CTRL_PROTO]);
          s_next.ttl_sel   = tri_sel_t'(pwdata[`CTRL_TTL]);
          s_next.frag_sel  = tri_sel_t'(pwdata[`CTRL_FRAG]);
          s_next.opt_sel   = tri_sel_t'(pwdata[`CTRL_OPT]);
          s_next.sip_sel   = ip_sel_t'(pwdata[`CTRL_SIP]);
          s_next.dip_sel   = ip_sel_t'(pwdata[`CTRL_DIP]);
        end
        ADDR_W'(`OFS_SRC_LO):   s_next.src_hw[31:0]  = pwdata;
        ADDR_W'(`OFS_SRC_HI):   s_next.src_hw[47:32] = pwdata[15:0];
        ADDR_W'(`OFS_DST_LO):   s_next.dst_hw[31:0]  = pwdata;
        ADDR_W'(`OFS_DST_HI):   s_next.dst_hw[47:32] = pwdata[15:0];
        ADDR_W'(`OFS_VID_PROTO): begin
          // a VLAN identifier of zero is not a legal setting and is ignored
          if (pwdata[`VP_VID] != `VID_NONE) begin
            s_next.vid = pwdata[`VP_VID];
          end
          s_next.proto = pwdata[`VP_PROTO];
        end
        ADDR_W'(`OFS_SIP):      s_next.source_net_address      = pwdata;
        ADDR_W'(`OFS_SIP_MASK): s_next.sip_mask = pwdata;
        ADDR_W'(`OFS_DIP):      s_next.destination_net_address      = pwdata;
        ADDR_W'(`OFS_DIP_MASK): s_next.dip_mask = pwdata;
        default: ;
      endcase
    end

    // a match in the clearing cycle is kept: counter restarts at one
    if (hdr_valid && hit_c) begin
      s_next.count = cnt_clear ? CNT_W'(1) : s_reg.count + CNT_W'(1);
    end else if (cnt_clear) begin
      s_next.count = '0;
    end

    if (setup) begin
      s_next.rerr  = !decode_hit(paddr);
      s_next.rdata = 32'h0000_0000;
      unique case (paddr)
        ADDR_W'(`OFS_CTRL): begin
          s_next.rdata[`CTRL_FTYPE]   = s_reg.ftype;
          s_next.rdata[`CTRL_DENY]    = s_reg.deny;
          s_next.rdata[`CTRL_SRC_EN]  = s_reg.src_spec;
          s_next.rdata[`CTRL_DST_SEL] = s_reg.dst_sel;
          s_next.rdata[`CTRL_VID]     = s_reg.vid_spec;
          s_next.rdata[`CTRL_PRIO_EN] = s_reg.prio_spec;
          s_next.rdata[`CTRL_PRIO]    = s_reg.prio;
          s_next.rdata[`CTRL_PROTO]   = s_reg.proto_sel;
          s_next.rdata[`CTRL_TTL]     = s_reg.ttl_sel;
          s_next.rdata[`CTRL_FRAG]    = s_reg.frag_sel;
          s_next.rdata[`CTRL_OPT]     = s_reg.opt_sel;
          s_next.rdata[`CTRL_SIP]     = s_reg.sip_sel;
          s_next.rdata[`CTRL_DIP]     = s_reg.dip_sel;
        end
        ADDR_W'(`OFS_SRC_LO):   s_next.rdata        = s_reg.src_hw[31:0];
        ADDR_W'(`OFS_SRC_HI):   s_next.rdata[15:0]  = s_reg.src_hw[47:32];
        ADDR_W'(`OFS_DST_LO):   s_next.rdata        = s_reg.dst_hw[31:0];
        ADDR_W'(`OFS_DST_HI):   s_next.rdata[15:0]  = s_reg.dst_hw[47:32];
        ADDR_W'(`OFS_VID_PROTO): begin
          s_next.rdata[`VP_VID]   = s_reg.vid;
          s_next.rdata[`VP_PROTO] = s_reg.proto;
        end
        ADDR_W'(`OFS_SIP):      s_next.rdata = s_reg.source_net_address;
        ADDR_W'(`OFS_SIP_MASK): s_next.rdata = s_reg.sip_mask;
        ADDR_W'(`OFS_DIP):      s_next.rdata = s_reg.destination_net_address;
        ADDR_W'(`OFS_DIP_MASK): s_next.rdata = s_reg.dip_mask;
        ADDR_W'(`OFS_COUNT):    s_next.rdata = 32'(s_reg.count);
        ADDR_W'(`OFS_STATUS): begin
          s_next.rdata[0] = s_reg.res_valid;
          s_next.rdata[1] = s_reg.res_hit;
          s_next.rdata[2] = s_reg.res_drop;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg          <= '0;
      s_reg.ftype    <= FT_ANY;
      s_reg.dst_sel  <= MAC_ANY;
      s_reg.vid      <= `VID_RESET;
      s_reg.sip_mask <= 32'hFFFF_FFFF;
      s_reg.dip_mask <= 32'hFFFF_FFFF;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_valid_latency: assert property (
    hdr_valid |-> ##`RESULT_DELAY match_valid)
    else $error("result not produced one cycle after strobe");

  chk_count_step: assert property (
    (hdr_valid && hit_c && !cnt_clear) |=> s_reg.count == $past(s_reg.count) + CNT_W'(1))
    else $error("counter did not step on a match");

  chk_count_hold: assert property (
    (!(hdr_valid && hit_c) && !cnt_clear) |=> $stable(s_reg.count))
    else $error("counter moved without a match");

  chk_drop_deny: assert property (
    (hdr_valid && hit_c && s_reg.deny) |=> match_drop && match_hit)
    else $error("denied match was not dropped");

  chk_ipv4_only: assert property (
    (hdr_valid && s_reg.ftype == FT_IPV4 && !frm_is_ipv4) |=> !match_hit)
    else $error("non IPv4 frame matched an IPv4 entry");

  chk_source_exact: assert property (
    (hdr_valid && (s_reg.ftype == FT_ETYPE || s_reg.ftype == FT_ARP) && s_reg.src_spec
     && frm_source_hw_address != s_reg.src_hw) |=> !match_hit)
    else $error("source address mismatch still matched");

  chk_ttl_zero: assert property (
    (hdr_valid && s_reg.ftype == FT_IPV4 && s_reg.ttl_sel == TRI_NO
     && frm_ttl != 8'h00) |=> !match_hit)
    else $error("nonzero time-to-live matched a zero setting");

  chk_frag_no: assert property (
    (hdr_valid && s_reg.ftype == FT_IPV4 && s_reg.frag_sel == TRI_NO
     && frm_more_fragments_bit) |=> !match_hit)
    else $error("fragment matched a no-fragment entry");

  chk_bcast_class: assert property (
    (hdr_valid && s_reg.dst_sel == MAC_ALL_HOSTS
     && !(&frm_destination_hw_address)) |=> !match_hit)
    else $error("non broadcast frame matched broadcast class");

  chk_all_any: assert property (
    (hdr_valid && s_reg.ftype == FT_ANY && s_reg.dst_sel == MAC_ANY
     && !s_reg.vid_spec && !s_reg.prio_spec) |=> match_hit)
    else $error("entry with every criterion open did not match");

  chk_drop_permit: assert property (
    (hdr_valid && !s_reg.deny)
    |=> !match_drop)
    else $error("permitted frame was dropped");

  chk_idle_quiet: assert property (
    !hdr_valid
    |=> !match_valid && !match_hit && !match_drop)
    else $error("result shown without a strobe");

  chk_count_clear: assert property (
    (cnt_clear && !(hdr_valid && hit_c))
    |=> s_reg.count == CNT_W'(0))
    else $error("counter not cleared by a write");

  chk_dest_exact: assert property (
    (hdr_valid && s_reg.dst_sel == MAC_SPECIFIC
     && frm_destination_hw_address != s_reg.dst_hw) |=> !match_hit)
    else $error("destination address mismatch still matched");

  chk_group_class: assert property (
    (hdr_valid && s_reg.dst_sel == MAC_GROUP
     && !frm_destination_hw_address[40]) |=> !match_hit)
    else $error("individual address matched group class");

  chk_single_class: assert property (
    (hdr_valid && s_reg.dst_sel == MAC_SINGLE
     && frm_destination_hw_address[40]) |=> !match_hit)
    else $error("group address matched single host class");

  chk_vid_exact: assert property (
    (hdr_valid && s_reg.vid_spec
     && frm_vid != s_reg.vid) |=> !match_hit)
    else $error("VLAN identifier mismatch still matched");

  chk_prio_exact: assert property (
    (hdr_valid && s_reg.prio_spec
     && frm_prio != s_reg.prio) |=> !match_hit)
    else $error("tag priority mismatch still matched");

  chk_proto_code: assert property (
    (hdr_valid && s_reg.ftype == FT_IPV4 && s_reg.proto_sel == PR_UDP
     && frm_ip_proto != `PROTO_UDP) |=> !match_hit)
    else $error("UDP entry matched another protocol");

  chk_opt_no: assert property (
    (hdr_valid && s_reg.ftype == FT_IPV4 && s_reg.opt_sel == TRI_NO
     && frm_ip_options) |=> !match_hit)
    else $error("frame with options matched a no-options entry");

  chk_src_host: assert property (
    (hdr_valid && s_reg.ftype == FT_IPV4 && s_reg.sip_sel == IP_HOST
     && frm_source_net_address != s_reg.source_net_address) |=> !match_hit)
    else $error("source net address mismatch still matched");

  chk_dst_net: assert property (
    (hdr_valid && s_reg.ftype == FT_IPV4 && s_reg.dip_sel == IP_NET
     && ((frm_destination_net_address ^ s_reg.destination_net_address) & s_reg.dip_mask) != 32'h0000_0000)
    |=> !match_hit)
    else $error("masked destination net address mismatch still matched");

endmodule

/* testbench/hdr_parser_model.sv */
// parser model: decoded header fields with a one-cycle strobe
// assumes the bench calls send() and shares clk with the matcher
`timescale 1ns/1ps
module hdr_parser_model (
  input  wire logic clk,
  output logic        hdr_valid,
  output logic        frm_is_arp,
  output logic        frm_is_ipv4,
  output logic [15:0] frm_len_type,
  output logic [47:0] frm_source_hw_address,
  output logic [47:0] frm_destination_hw_address,
  output logic [11:0] frm_vid,
  output logic [2:0]  frm_prio,
  output logic [7:0]  frm_ip_proto,
  output logic [7:0]  frm_ttl,
  output logic        frm_more_fragments_bit,
  output logic [12:0] frm_fragment_position,
  output logic        frm_ip_options,
  output logic [31:0] frm_source_net_address,
  output logic [31:0] frm_destination_net_address
);
  logic [223:0] f;
  initial begin
    hdr_valid = 1'b0;
    f         = '0;
  end
  assign {frm_is_arp, frm_is_ipv4, frm_len_type, frm_source_hw_address,
          frm_destination_hw_address, frm_vid, frm_prio, frm_ip_proto, frm_ttl,
          frm_more_fragments_bit, frm_fragment_position, frm_ip_options,
          frm_source_net_address, frm_destination_net_address} = f;
  // fields flip once released so a stale value never passes for a fresh one
  task automatic send(input logic [223:0] v);
    @(posedge clk);
    hdr_valid <= 1'b1;
    f         <= v;
    @(posedge clk);
    hdr_valid <= 1'b0;
    f         <= ~v;
  endtask
endmodule

/* testbench/tb.sv */
// bench for the entry matcher: apb setup, frames from the parser model
// assumes zero or more apb wait states and a result one cycle after the strobe
`timescale 1ns/1ps
`include "acl_defs.svh"
module tb import acl_pkg::*;;
  typedef struct packed {
    logic arp; logic ip4; logic [15:0] lt; logic [47:0] sa; logic [47:0] da;
    logic [11:0] vid; logic [2:0] pri; logic [7:0] pro; logic [7:0] ttl; logic more;
    logic [12:0] fo; logic opt; logic [31:0] source_net_address; logic [31:0] destination_net_address;
  } frm_t;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, e, deny;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, c;
  logic        hdr_valid, frm_is_arp, frm_is_ipv4, frm_more_fragments_bit, frm_ip_options;
  logic [15:0] frm_len_type;
  logic [47:0] frm_source_hw_address, frm_destination_hw_address;
  logic [11:0] frm_vid;
  logic [2:0]  frm_prio;
  logic [7:0]  frm_ip_proto, frm_ttl;
  logic [12:0] frm_fragment_position;
  logic [31:0] frm_source_net_address, frm_destination_net_address;
  logic        match_valid, match_hit, match_drop;
  frm_t        b;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          ecnt = 0;
  frame_acl_entry_matcher uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .hdr_valid, .frm_is_arp, .frm_is_ipv4, .frm_len_type,
    .frm_source_hw_address, .frm_destination_hw_address, .frm_vid, .frm_prio,
    .frm_ip_proto, .frm_ttl, .frm_more_fragments_bit, .frm_fragment_position,
    .frm_ip_options, .frm_source_net_address, .frm_destination_net_address,
    .match_valid, .match_hit, .match_drop);
  hdr_parser_model p (.clk, .hdr_valid, .frm_is_arp, .frm_is_ipv4, .frm_len_type,
    .frm_source_hw_address, .frm_destination_hw_address, .frm_vid, .frm_prio,
    .frm_ip_proto, .frm_ttl, .frm_more_fragments_bit, .frm_fragment_position,
    .frm_ip_options, .frm_source_net_address, .frm_destination_net_address);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task end_sim;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(e, 0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task frm(input frm_t f, input logic h);
    p.send(f);
    #1;
    chk(match_valid, 1);
    chk(match_hit, h);
    chk(match_drop, h & deny);
    if (h) ecnt++;
  endtask
  function frm_t ipx(input int k, input logic [31:0] m);
    ipx = b;
    if (k == 1) ipx.destination_net_address = b.destination_net_address ^ m;
    else ipx.source_net_address = b.source_net_address ^ m;
  endfunction
  task t_reset;
    apb(1'b0, `OFS_VID_PROTO, 32'h0);
    chk(q[11:0], `VID_RESET);
    rd(`OFS_SIP_MASK, 32'hFFFF_FFFF);
    rd(`OFS_COUNT, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk(e, 1);
    chk(q, 32'h0);
    frm(b, 1);
  endtask
  task t_src_mac;
    frm_t g;
    c = '0; c[`CTRL_FTYPE] = FT_ETYPE; c[`CTRL_SRC_EN] = 1'b1;
    wr(`OFS_CTRL, c);
    wr(`OFS_SRC_LO, b.sa[31:0]);
    wr(`OFS_SRC_HI, {16'h0, b.sa[47:32]});
    g = b; g.ip4 = 1'b0; g.lt = 16'h88B5;
    frm(g, 1);
    g.sa[47] = 1'b1;
    frm(g, 0);
    c[`CTRL_SRC_EN] = 1'b0;
    wr(`OFS_CTRL, c);
    frm(g, 1);
    c[`CTRL_SRC_EN] = 1'b1; c[`CTRL_FTYPE] = FT_IPV4;
    wr(`OFS_CTRL, c);
    g = b; g.sa[0] = ~b.sa[0];
    frm(g, 1);
  endtask
  task t_dst_mac;
    logic [47:0] da [3];
    logic [2:0]  ex [5];
    frm_t        g;
    da = '{48'hFFFF_FFFF_FFFF, 48'h0100_5E00_0001, b.da};
    ex = '{3'b111, 3'b010, 3'b100, 3'b001, 3'b001};
    wr(`OFS_DST_LO, b.da[31:0]);
    wr(`OFS_DST_HI, {16'h0, b.da[47:32]});
    g = b;
    for (int s = 0; s < 5; s++) begin
      c = '0; c[`CTRL_DST_SEL] = 3'(s);
      wr(`OFS_CTRL, c);
      for (int j = 0; j < 3; j++) begin
        g.da = da[j];
        frm(g, ex[s][2-j]);
      end
    end
  endtask
  task t_vlan;
    frm_t g;
    g = b; g.vid = 12'h065; g.pri = 3'h5;
    wr(`OFS_VID_PROTO, 32'h0000_0064);
    frm(g, 1);
    c = '0; c[`CTRL_VID] = 1'b1; c[`CTRL_PRIO_EN] = 1'b1; c[`CTRL_PRIO] = 3'h5;
    wr(`OFS_CTRL, c);
    g.vid = 12'h064;
    frm(g, 1);
    g.vid = 12'h065;
    frm(g, 0);
    g.vid = 12'h064; g.pri = 3'h4;
    frm(g, 0);
    wr(`OFS_VID_PROTO, 32'h0000_0FFF);
    g.vid = 12'hFFF; g.pri = 3'h5;
    frm(g, 1);
    wr(`OFS_VID_PROTO, 32'h0000_0000);
    frm(g, 1);
  endtask
  task t_proto;
    logic [7:0] pv [4];
    proto_sel_t ps [4];
    frm_t       g;
    pv = '{8'h01, 8'h11, 8'h06, 8'h2F};
    ps = '{PR_ICMP, PR_UDP, PR_TCP, PR_SPECIFIC};
    wr(`OFS_VID_PROTO, 32'h002F_0001);
    g = b;
    for (int i = 0; i < 4; i++) begin
      c = '0; c[`CTRL_FTYPE] = FT_IPV4; c[`CTRL_PROTO] = ps[i];
      wr(`OFS_CTRL, c);
      for (int j = 0; j < 4; j++) begin
        g.pro = pv[j];
        frm(g, i == j);
      end
    end
    g.ip4 = 1'b0; g.lt = 16'h88B5;
    frm(g, 0);
    c[`CTRL_PROTO] = PR_ANY;
    wr(`OFS_CTRL, c);
    g = b; g.pro = 8'h59;
    frm(g, 1);
  endtask
  task t_tri;
    frm_t na, ya;
    for (int k = 0; k < 3; k++) begin
      na = b; ya = b;
      if (k == 0) na.ttl = 8'h00;
      if (k == 1) ya.more = 1'b1;
      if (k == 2) ya.opt = 1'b1;
      c = '0; c[`CTRL_FTYPE] = FT_IPV4; c[15+2*k +: 2] = TRI_NO;
      wr(`OFS_CTRL, c);
      frm(na, 1);
      frm(ya, 0);
      c[15+2*k +: 2] = TRI_YES;
      wr(`OFS_CTRL, c);
      frm(ya, 1);
      c[15+2*k +: 2] = TRI_ANY;
      wr(`OFS_CTRL, c);
      frm(ya, 1);
    end
    c[`CTRL_FRAG] = TRI_NO;
    wr(`OFS_CTRL, c);
    ya = b; ya.fo = 13'h0005;
    frm(ya, 0);
  endtask
  task t_ip;
    for (int k = 0; k < 2; k++) begin
      wr(`OFS_SIP + 8'(8*k), (k == 1) ? b.destination_net_address : b.source_net_address);
      wr(`OFS_SIP_MASK + 8'(8*k), 32'hFFFF_FF00);
      c = '0; c[`CTRL_FTYPE] = FT_IPV4; c[21+2*k +: 2] = IP_HOST;
      wr(`OFS_CTRL, c);
      frm(ipx(k, 32'h0), 1);
      frm(ipx(k, 32'h1), 0);
      c[21+2*k +: 2] = IP_NET;
      wr(`OFS_CTRL, c);
      frm(ipx(k, 32'hFF), 1);
      frm(ipx(k, 32'h100), 0);
      c[21+2*k +: 2] = IP_ANY;
      wr(`OFS_CTRL, c);
      frm(ipx(k, 32'hFFFF), 1);
    end
  endtask
  task t_count;
    frm_t g;
    c = '0; c[`CTRL_DENY] = 1'b1; c[`CTRL_FTYPE] = FT_IPV4;
    wr(`OFS_CTRL, c);
    deny = 1'b1;
    frm(b, 1);
    g = b; g.ip4 = 1'b0; g.lt = 16'h88B5;
    frm(g, 0);
    rd(`OFS_COUNT, 32'(ecnt));
    wr(`OFS_COUNT, 32'h0);
    ecnt = 0;
    rd(`OFS_COUNT, 32'h0);
  endtask
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; deny = 1'b0;
    paddr = '0; pwdata = '0; c = '0;
    b = '{1'b0, 1'b1, 16'h0800, 48'h0A0B_0C0D_0E0F, 48'h0211_2233_4455, 12'h001, 3'h0,
          8'h06, 8'h40, 1'b0, 13'h0000, 1'b0, 32'h0A00_0001, 32'h0A00_0102};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_src_mac;
    t_dst_mac;
    t_vlan;
    t_proto;
    t_tri;
    t_ip;
    t_count;
    end_sim;
  end
endmodule
